// ==== rtl/gtpc_top.sv ====
// Gate transfer privilege checker with inner stack switch, Avalon-MM slave
`timescale 1ns/1ns
`include "gtpc_defines.svh"
module gtpc_top
  import gtpc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Status levels
  output logic      [1:0]  cur_level_out,
  output logic      [1:0]  fault_out,
  output logic             busy_out
);
  // Control: [0] start, [1] branch kind, [2] table select (global 0, local 1)
  logic [31:0] far_off;
  logic [15:0] far_sel;
  logic        kind_branch;
  logic        tbl_local;
  // Gate: lo = {offset[15:0], sel[15:0]}, hi = {offset[31:16], p, dpl[1:0], is32, cnt[4:0], 7'b0}
  logic [31:0] gate_lo;
  logic [31:0] gate_hi;
  logic [31:0] code_base;
  // Code attr: [1:0] dpl, [2] conforming, [3] present, [4] executable
  logic [4:0]  code_attr;
  // Stack attr: [1:0] dpl, [2] writable data, [3] present, [4] limit ok
  logic [4:0]  stk_attr;
  // Per-level inner stack pairs; levels 0..2 only, no level 3 entry
  logic [15:0] stk_sel  [3];
  logic [31:0] stk_ptr  [3];
  logic [1:0]  current_priv_level;
  logic [15:0] ss_reg;
  logic [31:0] sp_reg;
  logic [15:0] cs_reg;
  logic [31:0] ip_reg;
  logic [15:0] held_ss;
  logic [31:0] held_sp;
  logic [31:0] old_sp;
  logic [31:0] entry;
  logic [4:0]  copy_left;
  logic [31:0] mem_addr;
  logic [31:0] mem_data;
  logic [31:0] param_in;
  logic        done;
  gtpc_fault_t fault;
  gtpc_state_t state;
  logic        start;
  logic        wait_q;

  logic [1:0]  gate_dpl;
  logic        gate_p;
  logic        gate_32;
  logic [4:0]  gate_cnt;
  logic [1:0]  requestor_priv_level;
  logic [1:0]  tgt_dpl;
  logic        tgt_conf;
  logic        priv_ok;
  logic        inner;
  logic [31:0] item_sz;

  assign gate_dpl = gate_hi[14:13];
  assign gate_p   = gate_hi[15];
  assign gate_32  = gate_hi[12];
  assign gate_cnt = gate_hi[11:7];
  assign requestor_priv_level      = far_sel[1:0];
  assign tgt_dpl  = code_attr[1:0];
  assign tgt_conf = code_attr[2];
  assign item_sz  = gate_32 ? 32'h4 : 32'h2;

  always_comb begin
    priv_ok = (current_priv_level <= gate_dpl) && (requestor_priv_level <= gate_dpl);
    if (tgt_conf) begin
      priv_ok = priv_ok && (tgt_dpl <= current_priv_level);
    end else if (kind_branch) begin
      priv_ok = priv_ok && (tgt_dpl == current_priv_level);
    end else begin
      priv_ok = priv_ok && (tgt_dpl <= current_priv_level);
    end
    priv_ok = priv_ok && code_attr[4];
  end
  // Only an inner call to nonconforming code switches; never outward
  assign inner = !kind_branch && !tgt_conf && (tgt_dpl < current_priv_level);

  // Bus side: one wait cycle, then answer; while busy every write is dropped except to PARAM_IN
  wire acc = (avs_read_in || avs_write_in) && !wait_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      wait_q              <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      wait_q              <= acc;
      avs_waitrequest_out <= !acc;
    end
  end

  wire wr_now = avs_write_in && wait_q;
  wire rd_now = avs_read_in && acc;
  assign start = wr_now && (avs_address_in == `GTPC_OFF_CTRL) && avs_writedata_in[0]
                 && avs_byteenable_in[0] && (state == GTPC_IDLE);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      far_sel     <= 16'h0000;
      far_off     <= 32'h00000000;
      kind_branch <= 1'b0;
      tbl_local   <= 1'b0;
      gate_lo     <= 32'h00000000;
      gate_hi     <= 32'h00000000;
      code_base   <= 32'h00000000;
      code_attr   <= 5'h00;
      stk_attr    <= 5'h00;
      param_in    <= 32'h00000000;
    end else if (wr_now && state == GTPC_IDLE) begin
      unique case (avs_address_in)
        `GTPC_OFF_CTRL: begin
          kind_branch <= avs_writedata_in[1];
          tbl_local   <= avs_writedata_in[2];
        end
        `GTPC_OFF_FAR_SEL:   far_sel   <= avs_writedata_in[15:0];
        `GTPC_OFF_FAR_OFF:   far_off   <= avs_writedata_in;
        `GTPC_OFF_GATE_LO:   gate_lo   <= avs_writedata_in;
        `GTPC_OFF_GATE_HI:   gate_hi   <= avs_writedata_in;
        `GTPC_OFF_CODE_BASE: code_base <= avs_writedata_in;
        `GTPC_OFF_CODE_ATTR: code_attr <= avs_writedata_in[4:0];
        `GTPC_OFF_STK_ATTR:  stk_attr  <= avs_writedata_in[4:0];
        `GTPC_OFF_PARAM_IN:  param_in  <= avs_writedata_in;
        default: ;
      endcase
    end else if (wr_now && avs_address_in == `GTPC_OFF_PARAM_IN) begin
      param_in <= avs_writedata_in;
    end
  end

  // Inner stack table: written by software only, read-only to the sequencer
  genvar lv;
  generate
    for (lv = 0; lv < 3; lv++) begin : g_lvl
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          stk_sel[lv] <= 16'h0000;
          stk_ptr[lv] <= 32'h00000000;
        end else if (wr_now && state == GTPC_IDLE && far_off[1:0] == 2'(lv)) begin
          if (avs_address_in == `GTPC_OFF_STK_SEL) stk_sel[lv] <= avs_writedata_in[15:0];
          if (avs_address_in == `GTPC_OFF_STK_PTR) stk_ptr[lv] <= avs_writedata_in;
        end
      end
    end
  endgenerate

  // Transfer sequencer
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state     <= GTPC_IDLE;
      current_priv_level       <= `GTPC_RST_CPL;
      ss_reg    <= 16'h0000;
      sp_reg    <= 32'h00000000;
      cs_reg    <= 16'h0000;
      ip_reg    <= 32'h00000000;
      held_ss   <= 16'h0000;
      held_sp   <= 32'h00000000;
      old_sp    <= 32'h00000000;
      entry     <= 32'h00000000;
      copy_left <= 5'h00;
      mem_addr  <= 32'h00000000;
      mem_data  <= 32'h00000000;
      fault     <= GTPC_FAULT_NONE;
      done      <= 1'b0;
    end else begin
      unique case (state)
        GTPC_IDLE: begin
          if (start) begin
            done  <= 1'b0;
            fault <= GTPC_FAULT_NONE;
            state <= GTPC_CHECK;
          end else if (wr_now && avs_address_in == `GTPC_OFF_CUR) begin
            // Caller context set by software; only inner calls lower it
            cs_reg <= avs_writedata_in[17:2];
            current_priv_level    <= avs_writedata_in[1:0];
          end
        end
        GTPC_CHECK: begin
          if (!gate_p) begin
            fault <= GTPC_FAULT_ABSENT;
            state <= GTPC_IDLE;
          end else if (!priv_ok) begin
            fault <= GTPC_FAULT_PROT;
            state <= GTPC_IDLE;
          end else begin
            entry <= code_base + {gate_hi[31:16], gate_lo[31:16]};
            state <= inner ? GTPC_STACK : GTPC_LOAD;
          end
        end
        GTPC_STACK: begin
          if (!stk_attr[4] || !stk_attr[3]) begin
            fault <= GTPC_FAULT_TASK;
            state <= GTPC_IDLE;
          end else if (!stk_attr[2] || stk_attr[1:0] != tgt_dpl) begin
            fault <= GTPC_FAULT_TASK;
            state <= GTPC_IDLE;
          end else begin
            held_ss <= ss_reg;
            held_sp <= sp_reg;
            old_sp  <= sp_reg;
            ss_reg  <= stk_sel[tgt_dpl];
            sp_reg  <= stk_ptr[tgt_dpl];
            current_priv_level     <= tgt_dpl;
            state   <= GTPC_PUSH_SS;
          end
        end
        GTPC_PUSH_SS: begin
          sp_reg   <= sp_reg - item_sz;
          mem_addr <= sp_reg - item_sz;
          mem_data <= {16'h0000, held_ss};
          state    <= GTPC_PUSH_SP;
        end
        GTPC_PUSH_SP: begin
          sp_reg    <= sp_reg - item_sz;
          mem_addr  <= sp_reg - item_sz;
          mem_data  <= held_sp;
          copy_left <= gate_cnt;
          state     <= (gate_cnt == 5'h00) ? GTPC_PUSH_CS : GTPC_COPY;
        end
        GTPC_COPY: begin
          sp_reg    <= sp_reg - item_sz;
          mem_addr  <= sp_reg - item_sz;
          mem_data  <= gate_32 ? param_in : {16'h0000, param_in[15:0]};
          old_sp    <= old_sp + item_sz;
          copy_left <= copy_left - 5'h01;
          if (copy_left == 5'h01) state <= GTPC_PUSH_CS;
        end
        GTPC_PUSH_CS: begin
          sp_reg   <= sp_reg - item_sz;
          mem_addr <= sp_reg - item_sz;
          mem_data <= {16'h0000, cs_reg};
          state    <= GTPC_PUSH_IP;
        end
        GTPC_PUSH_IP: begin
          sp_reg   <= sp_reg - item_sz;
          mem_addr <= sp_reg - item_sz;
          mem_data <= ip_reg;
          state    <= GTPC_LOAD;
        end
        GTPC_LOAD: begin
          cs_reg <= gate_lo[15:0];
          ip_reg <= entry;
          done   <= 1'b1;
          state  <= GTPC_IDLE;
        end
      endcase
    end
  end

  // Read data and status pins
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= 32'h00000000;
      cur_level_out    <= `GTPC_RST_CPL;
      fault_out        <= 2'h0;
      busy_out         <= 1'b0;
    end else begin
      cur_level_out <= current_priv_level;
      fault_out     <= fault;
      busy_out      <= (state != GTPC_IDLE);
      if (rd_now) begin
        unique case (avs_address_in)
          `GTPC_OFF_CTRL:      avs_readdata_out <= {29'h0, tbl_local, kind_branch, 1'b0};
          `GTPC_OFF_FAR_SEL:   avs_readdata_out <= {16'h0000, far_sel};
          `GTPC_OFF_CUR:       avs_readdata_out <= {14'h0, cs_reg, current_priv_level};
          `GTPC_OFF_GATE_LO:   avs_readdata_out <= gate_lo;
          `GTPC_OFF_GATE_HI:   avs_readdata_out <= gate_hi;
          `GTPC_OFF_STK_SEL:   avs_readdata_out <= {16'h0000, ss_reg};
          `GTPC_OFF_STK_PTR:   avs_readdata_out <= sp_reg;
          `GTPC_OFF_STATUS:    avs_readdata_out <= {28'h0, fault, done, (state != GTPC_IDLE)};
          `GTPC_OFF_ENTRY:     avs_readdata_out <= ip_reg;
          `GTPC_OFF_MEM_ADDR:  avs_readdata_out <= mem_addr;
          `GTPC_OFF_MEM_DATA:  avs_readdata_out <= mem_data;
          default:             avs_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ==== rtl/gtpc_defines.svh ====
// Offsets, field positions, reset values and parameter limit for the gate transfer checker
`ifndef GTPC_DEFINES_SVH
`define GTPC_DEFINES_SVH
`define GTPC_OFF_CTRL      4'h0
`define GTPC_OFF_FAR_SEL   4'h1
`define GTPC_OFF_FAR_OFF   4'h2
`define GTPC_OFF_CUR       4'h3
`define GTPC_OFF_GATE_LO   4'h4
`define GTPC_OFF_GATE_HI   4'h5
`define GTPC_OFF_CODE_BASE 4'h6
`define GTPC_OFF_CODE_ATTR 4'h7
`define GTPC_OFF_STK_SEL   4'h8
`define GTPC_OFF_STK_PTR   4'h9
`define GTPC_OFF_STK_ATTR  4'ha
`define GTPC_OFF_STATUS    4'hb
`define GTPC_OFF_ENTRY     4'hc
`define GTPC_OFF_MEM_ADDR  4'hd
`define GTPC_OFF_MEM_DATA  4'he
`define GTPC_OFF_PARAM_IN  4'hf
`define GTPC_MAX_PARAMS    5'h1f
`define GTPC_RST_CPL       2'h0
`define GTPC_STATUS_BUSY   0
`define GTPC_STATUS_DONE   1
`endif

// ==== rtl/gtpc_pkg.sv ====
// Types for the gate transfer checker
package gtpc_pkg;
  typedef enum logic [1:0] {
    GTPC_FAULT_NONE,
    GTPC_FAULT_PROT,
    GTPC_FAULT_ABSENT,
    GTPC_FAULT_TASK
  } gtpc_fault_t;
  typedef enum {
    GTPC_IDLE,
    GTPC_CHECK,
    GTPC_STACK,
    GTPC_PUSH_SS,
    GTPC_PUSH_SP,
    GTPC_COPY,
    GTPC_PUSH_CS,
    GTPC_PUSH_IP,
    GTPC_LOAD
  } gtpc_state_t;
endpackage

// ==== tb/gtpc_tss_model.sv ====
// Stack table of the task state block, as software would lay it out
`timescale 1ns/1ns
module gtpc_tss_model #(
  parameter logic [31:0] SEL_BASE = 32'h0000_0010,
  parameter logic [31:0] PTR_TOP  = 32'h0000_8000
) (
  // One selector and pointer per inner level
  output logic [31:0] sel_out [3],
  output logic [31:0] ptr_out [3]
);
  // Only levels 0 to 2 have an entry; held constant for the run
  always_comb begin
    for (int l = 0; l < 3; l++) begin
      sel_out[l] = SEL_BASE + 32'(l * 8);
      ptr_out[l] = PTR_TOP - 32'(l * 4096);
    end
  end
endmodule

// ==== tb/gtpc_monitor.sv ====
// Concurrent checks on the gate transfer block ports
`timescale 1ns/1ns
module gtpc_monitor
  import gtpc_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  // Bus side
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // Status
  input wire logic [1:0]  cur_level_out,
  input wire logic [1:0]  fault_out,
  input wire logic        busy_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_req; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
  sequence s_ans; ##1 !avs_waitrequest_out ##1 avs_waitrequest_out; endsequence
  sequence s_go;
    avs_write_in && !avs_waitrequest_out && avs_address_in == 4'h0 && avs_writedata_in[0]
    && !busy_out;
  endsequence
  property p_answer; s_req |-> s_ans; endproperty
  property p_cause; $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in); endproperty
  property p_rdhold; $changed(avs_readdata_out) |-> $past(avs_read_in); endproperty
  property p_start; s_go |-> ##[1:3] busy_out; endproperty
  property p_end; $rose(busy_out) |-> ##[1:50] !busy_out; endproperty
  // Software may load the caller level; that write shows two samples later
  property p_down;
    !($past(avs_write_in, 2) && $past(avs_address_in, 2) == 4'h3)
    |-> cur_level_out <= $past(cur_level_out);
  endproperty
  property p_top;
    $past(cur_level_out) != 2'h3 && !($past(avs_write_in, 2) && $past(avs_address_in, 2) == 4'h3)
    |-> cur_level_out != 2'h3;
  endproperty
  property p_prot;
    fault_out == GTPC_FAULT_PROT && !($past(avs_write_in, 2) && $past(avs_address_in, 2) == 4'h3)
    |-> $stable(cur_level_out);
  endproperty
  property p_absent;
    fault_out == GTPC_FAULT_ABSENT
    && !($past(avs_write_in, 2) && $past(avs_address_in, 2) == 4'h3)
    |-> $stable(cur_level_out);
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");
  a_cause: assert property (p_cause) else $error("answer without request");
  a_rdhold: assert property (p_rdhold) else $error("read data moved without read");
  a_start: assert property (p_start) else $error("start did not raise busy");
  a_end: assert property (p_end) else $error("transfer did not finish");
  a_down: assert property (p_down) else $error("level rose without return");
  a_top: assert property (p_top) else $error("level three entered");
  a_prot: assert property (p_prot) else $error("level moved on protection fault");
  a_absent: assert property (p_absent) else $error("level moved on absent gate");
endmodule
bind gtpc_top gtpc_monitor u_mon (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .cur_level_out(cur_level_out),
  .fault_out(fault_out), .busy_out(busy_out));

// ==== tb/tb_top.sv ====
// Self-checking bench for the gate transfer block
`timescale 1ns/1ns
module tb_top
  import gtpc_pkg::*;
;
  logic        clk_sys_in = 0;
  logic        rstn_in = 0;
  logic [3:0]  avs_address_in = '0;
  logic        avs_read_in = 0;
  logic        avs_write_in = 0;
  logic [31:0] avs_writedata_in = '0;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [1:0]  cur_level_out;
  logic [1:0]  fault_out;
  logic        busy_out;
  logic [31:0] tss_sel [3];
  logic [31:0] tss_ptr [3];
  logic [31:0] q [$];
  logic [31:0] prev_ip;
  int          errors = 0;
  int          checked = 0;
  int          seed = 32'h6c360dd0;

  gtpc_top DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .cur_level_out(cur_level_out),
    .fault_out(fault_out), .busy_out(busy_out));
  gtpc_tss_model u_tss (.sel_out(tss_sel), .ptr_out(tss_ptr));

  always #50 clk_sys_in = ~clk_sys_in;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    errors += q.size();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= rd;
    avs_write_in <= !rd;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    // Let the release reach an edge before the next request
    @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask

  // Read answers are matched against the oldest expectation
  always @(posedge clk_sys_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0 && q.size() > 0) begin
      chk(avs_readdata_out, q.pop_front());
    end
  end

  task automatic xfer(input logic br, conf, input logic [1:0] cdpl, requestor_priv_level, gdpl, input logic pres);
    logic [31:0] off;
    logic [31:0] base;
    logic [1:0]  ef;
    int          n;
    off = $random(seed);
    base = $random(seed);
    n = 0;
    if (!pres) ef = GTPC_FAULT_ABSENT;
    else if (2'h0 > gdpl || requestor_priv_level > gdpl) ef = GTPC_FAULT_PROT;
    else if ((conf || !br) ? cdpl > 2'h0 : cdpl != 2'h0) ef = GTPC_FAULT_PROT;
    else ef = GTPC_FAULT_NONE;
    bus(1'b0, 4'h1, {30'h0, requestor_priv_level});
    bus(1'b0, 4'h2, $random(seed));
    bus(1'b0, 4'h4, {off[15:0], 16'h0008});
    bus(1'b0, 4'h5, {off[31:16], pres, gdpl, 6'($random(seed)), 7'h0});
    bus(1'b0, 4'h6, base);
    bus(1'b0, 4'h7, {27'h0, 2'b11, conf, cdpl});
    bus(1'b0, 4'h0, {29'h0, br ^ conf, br, 1'b1});
    repeat (3) @(posedge clk_sys_in);
    while (busy_out !== 1'b0 && n < 100) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 100) begin
      errors++;
      print_verdict();
    end
    chk({30'h0, fault_out}, {30'h0, ef});
    chk({30'h0, cur_level_out}, 32'h0);
    if (ef == GTPC_FAULT_NONE) prev_ip = base + off;
    rd(4'hc, prev_ip);
  endtask

  // Call from level 3 to an inner nonconforming segment, with stack switch
  task automatic inner_call(input logic [1:0] tl, input logic g32, input logic [4:0] cnt,
                            input logic bad);
    logic [31:0] sz;
    int          n;
    n = 0;
    sz = g32 ? 32'h4 : 32'h2;
    bus(1'b0, 4'h3, {14'h0, 16'h0023, 2'h3});
    bus(1'b0, 4'h1, 32'h3);
    bus(1'b0, 4'h4, {16'h1234, 16'h0008});
    bus(1'b0, 4'h5, {16'h0000, 1'b1, 2'h3, g32, cnt, 7'h0});
    bus(1'b0, 4'h6, 32'h0001_0000);
    bus(1'b0, 4'h7, {27'h0, 2'b11, 1'b0, tl});
    bus(1'b0, 4'ha, {27'h0, 2'b11, !bad, tl});
    bus(1'b0, 4'hf, $random(seed));
    bus(1'b0, 4'h0, 32'h1);
    repeat (3) @(posedge clk_sys_in);
    while (busy_out !== 1'b0 && n < 100) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 100) begin
      errors++;
      print_verdict();
    end
    if (bad) begin
      chk({30'h0, fault_out}, {30'h0, GTPC_FAULT_TASK});
      chk({30'h0, cur_level_out}, 32'h3);
      rd(4'hc, prev_ip);
    end else begin
      chk({30'h0, fault_out}, {30'h0, GTPC_FAULT_NONE});
      chk({30'h0, cur_level_out}, {30'h0, tl});
      rd(4'h8, {16'h0000, tss_sel[tl][15:0]});
      rd(4'h9, tss_ptr[tl] - sz * (32'(cnt) + 32'h4));
      rd(4'hd, tss_ptr[tl] - sz * (32'(cnt) + 32'h4));
      rd(4'he, prev_ip);
      rd(4'h3, {14'h0, 16'h0008, tl});
      prev_ip = 32'h0001_1234;
      rd(4'hc, prev_ip);
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    for (int l = 0; l < 3; l++) begin
      bus(1'b0, 4'h2, 32'(l));
      bus(1'b0, 4'h8, tss_sel[l]);
      bus(1'b0, 4'h9, tss_ptr[l]);
    end
    for (int i = 0; i < 16; i++) begin
      xfer(i[0], i[1], {1'b0, i[2]}, {1'b1, i[3]}, 2'h2, 1'b1);
    end
    xfer(1'b0, 1'b0, 2'h0, 2'h0, 2'h3, 1'b0);
    xfer(1'b1, 1'b1, 2'h0, 2'h1, 2'h1, 1'b1);
    inner_call(2'h0, 1'b1, 5'h03, 1'b0);
    inner_call(2'h1, 1'b0, 5'h00, 1'b0);
    inner_call(2'h2, 1'b1, 5'h1f, 1'b0);
    inner_call(2'h1, 1'b1, 5'h02, 1'b1);
    repeat (2) @(posedge clk_sys_in);
    print_verdict();
  end
endmodule
